// >>> design/sched_map.vh
// register offsets, field layouts, reset values and timing counts of the measurement scheduler
// Contract
// - zero signal period runs cycles back to back, else at least period ms apart.
// - signal range codes -1 auto, 1 50mV, 2 500mV, 3 5V; reset auto.
// - zero offset period measures offsets every cycle, else period s apart; reset 30.
// - during offset measurement the input switches isolate the detectors.
// - offset range follows signal range when period zero and follow flag set.
// - zero frequency period measures every cycle, else period ms apart; reset 0.
// - CW frequency gate time in microseconds, reset 10000.
// - counter off reports substitute frequency; reset on.
// - CW voltage averaging count 1 to 4095, reset 16.
// - CW sample rate in samples per second, default and maximum 200000.
// - zero temperature period measures every cycle, else period s apart; reset 30.
// - temperature readings average a count of samples, reset 8.
// - request byte bits: ready 0, results timer 1, motors timer 2, alarm 3.
// - send only when request flags AND enable mask is nonzero.
// - enable mask resets to 255.
// - results-ready request raised after each successful measurement.
// - results timer raises bit 1 each interval ms, restarts on send; reset 0.
// - motors timer raises bit 2 each interval, default 100 ms, restarts on send.
// - swap alarm event raises bit 3 and sends an alarm message.
`ifndef SCHED_MAP_VH
`define SCHED_MAP_VH
`define A_SIG_PERIOD    4'h0
`define A_SIG_RANGE     4'h1
`define A_OFS_PERIOD    4'h2
`define A_OFS_RANGE     4'h3
`define A_FREQ_PERIOD   4'h4
`define A_GATE_TIME     4'h5
`define A_CTRL          4'h6
`define A_AVG_COUNT     4'h7
`define A_SAMPLE_RATE   4'h8
`define A_TEMP_PERIOD   4'h9
`define A_TEMP_AVG      4'ha
`define A_MASK          4'hb
`define A_RES_INTERVAL  4'hc
`define A_MOT_INTERVAL  4'hd
`define A_STATUS        4'he
`define A_FLAGS         4'hf
`define CTRL_FOLLOW_BIT 0
`define CTRL_CNT_ON_BIT 1
`define CTRL_CW_BIT     2
`define CTRL_RUN_BIT    3
`define RST_SIG_PERIOD  16'h0000
`define RST_SIG_RANGE   3'h7
`define RST_OFS_PERIOD  16'h001e
`define RST_OFS_RANGE   3'h2
`define RST_FREQ_PERIOD 16'h0000
`define RST_GATE_TIME   16'h2710
`define RST_CTRL        4'hb
`define RST_AVG_COUNT   12'h010
`define RST_SAMPLE_RATE 18'h30d40
`define MAX_SAMPLE_RATE 18'h30d40
`define RST_TEMP_PERIOD 16'h001e
`define RST_TEMP_AVG    8'h08
`define RST_MASK        8'hff
`define RST_RES_INT     16'h0000
`define RST_MOT_INT     16'h0064
`define RANGE_AUTO      3'h7
`define RANGE_50MV      3'h1
`define RANGE_500MV     3'h2
`define RANGE_5V        3'h3
`define BIT_READY       0
`define BIT_RES_TIME    1
`define BIT_MOT_TIME    2
`define BIT_ALARM       3
`define CLK_MHZ         100
`define MS_US           1000
`define S_MS            1000
`define S_DIV_LAST      10'h3e7
`define US_CYCLES       (`CLK_MHZ)
`define MS_CYCLES       (`CLK_MHZ * `MS_US)
`endif

// >>> design/period_gate.v
// elapsed-time gate: ready once period units have passed since the last restart
`timescale 1ns/1ns
module period_gate
(
   input  wire        clock_i,
   input  wire        rst_i,
   input  wire        tick_i,
   input  wire        restart_i,
   input  wire [15:0] period_i,
   output reg         due_o
);
   // the first tick after a restart may come at once, so due waits for period+1 ticks
   // and the spacing is never short of the full period
   reg [16:0] count_r;

   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         count_r <= 17'h00000;
         due_o   <= 1'b1;
      end
      else if (restart_i)
      begin
         count_r <= 17'h00000;
         due_o   <= (period_i == 16'h0000);
      end
      else
      begin
         if (tick_i && !due_o)
            count_r <= count_r + 17'h00001;
         // saturates: once due it stays due until the next restart
         if (period_i == 16'h0000 || count_r > {1'b0, period_i})
            due_o <= 1'b1;
      end
   end
endmodule

// >>> design/measure_schedule_send_gate.v
// measurement scheduler, configuration registers and send-request gate
`timescale 1ns/1ns
`include "sched_map.vh"
module measure_schedule_send_gate
#(
   parameter MS_CYCLES = `MS_CYCLES
)
(
   input  wire        clock_i,
   input  wire        rst_i,
   input  wire [3:0]  addr_i,
   input  wire [31:0] wdata_i,
   input  wire        wr_i,
   input  wire        rd_i,
   output reg  [31:0] rdata_o,
   input  wire        meas_ok_i,
   input  wire        swap_alarm_i,
   input  wire        loop_pass_i,
   output reg         cycle_start_o,
   output reg         do_offset_o,
   output reg         do_freq_o,
   output reg         do_temp_o,
   output reg         detector_isolate_o,
   output reg  [2:0]  signal_range_o,
   output reg  [2:0]  offset_range_o,
   output reg  [15:0] gate_time_o,
   output reg         substitute_freq_o,
   output reg  [11:0] avg_count_o,
   output reg  [17:0] sample_rate_o,
   output reg  [7:0]  temp_avg_o,
   output reg         send_o,
   output reg         send_full_o,
   output reg         send_last_o,
   output reg         send_motor_o,
   output reg         send_alarm_o
);
   // ************************************************************
   // configuration registers
   // ************************************************************
   reg [15:0] signal_meas_period_r;
   reg [2:0]  signal_adc_range_r;
   reg [15:0] offset_meas_period_r;
   reg [2:0]  offset_adc_range_r;
   reg [15:0] freq_meas_period_r;
   reg [15:0] cw_count_gate_time_r;
   reg [3:0]  ctrl_r;
   reg [11:0] avg_cnt_r;
   reg [17:0] sample_rate_r;
   reg [15:0] temp_meas_period_r;
   reg [7:0]  temp_avg_count_r;
   reg [7:0]  send_enable_mask_r;
   reg [15:0] results_send_interval_r;
   reg [15:0] motor_send_interval_r;
   reg [7:0]  send_request_flags_r;
   reg [16:0] ms_div_r;
   reg [9:0]  s_div_r;
   reg        ms_tick_r;
   reg        s_tick_r;
   reg        offset_phase_r;
   reg [7:0]  flags_nxt;
   reg [31:0] rdata_nxt;

   wire follow_w = ctrl_r[`CTRL_FOLLOW_BIT];
   wire cnt_on_w = ctrl_r[`CTRL_CNT_ON_BIT];
   wire cw_w     = ctrl_r[`CTRL_CW_BIT];
   wire run_w    = ctrl_r[`CTRL_RUN_BIT];
   wire sig_due_w;
   wire ofs_due_w;
   wire frq_due_w;
   wire tmp_due_w;
   wire res_due_w;
   wire mot_due_w;
   wire start_w = run_w && sig_due_w && !cycle_start_o && !offset_phase_r;
   wire [7:0] granted_w = send_request_flags_r & send_enable_mask_r;

   // legal range codes only; anything else keeps the old setting
   function range_ok;
      input [2:0] code;
      begin
         range_ok = (code == `RANGE_AUTO) || (code == `RANGE_50MV) ||
                    (code == `RANGE_500MV) || (code == `RANGE_5V);
      end
   endfunction

   function [2:0] range_enc;
      input [31:0] value;
      begin
         // -1 arrives as all ones; keep the low three bits
         range_enc = value[2:0];
      end
   endfunction

   function [31:0] range_dec;
      input [2:0] code;
      begin
         range_dec = (code == `RANGE_AUTO) ? 32'hffffffff : {29'h0, code};
      end
   endfunction

   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         signal_meas_period_r    <= `RST_SIG_PERIOD;
         signal_adc_range_r      <= `RST_SIG_RANGE;
         offset_meas_period_r    <= `RST_OFS_PERIOD;
         offset_adc_range_r      <= `RST_OFS_RANGE;
         freq_meas_period_r      <= `RST_FREQ_PERIOD;
         cw_count_gate_time_r    <= `RST_GATE_TIME;
         ctrl_r                  <= `RST_CTRL;
         avg_cnt_r               <= `RST_AVG_COUNT;
         sample_rate_r           <= `RST_SAMPLE_RATE;
         temp_meas_period_r      <= `RST_TEMP_PERIOD;
         temp_avg_count_r        <= `RST_TEMP_AVG;
         send_enable_mask_r      <= `RST_MASK;
         results_send_interval_r <= `RST_RES_INT;
         motor_send_interval_r   <= `RST_MOT_INT;
      end
      else if (wr_i)
      begin
         case (addr_i)
            `A_SIG_PERIOD:   signal_meas_period_r <= wdata_i[15:0];
            `A_SIG_RANGE:
               if (range_ok(range_enc(wdata_i)))
                  signal_adc_range_r <= range_enc(wdata_i);
            `A_OFS_PERIOD:   offset_meas_period_r <= wdata_i[15:0];
            `A_OFS_RANGE:
               if (range_ok(range_enc(wdata_i)))
                  offset_adc_range_r <= range_enc(wdata_i);
            `A_FREQ_PERIOD:  freq_meas_period_r <= wdata_i[15:0];
            `A_GATE_TIME:    cw_count_gate_time_r <= wdata_i[15:0];
            `A_CTRL:         ctrl_r <= wdata_i[3:0];
            `A_AVG_COUNT:
               if (wdata_i[11:0] != 12'h000)
                  avg_cnt_r <= wdata_i[11:0];
            `A_SAMPLE_RATE:
               if (wdata_i[17:0] != 18'h00000 && wdata_i[17:0] <= `MAX_SAMPLE_RATE && wdata_i[31:18] == 14'h0)
                  sample_rate_r <= wdata_i[17:0];
            `A_TEMP_PERIOD:  temp_meas_period_r <= wdata_i[15:0];
            `A_TEMP_AVG:
               if (wdata_i[7:0] != 8'h00)
                  temp_avg_count_r <= wdata_i[7:0];
            `A_MASK:         send_enable_mask_r <= wdata_i[7:0];
            `A_RES_INTERVAL: results_send_interval_r <= wdata_i[15:0];
            `A_MOT_INTERVAL: motor_send_interval_r <= wdata_i[15:0];
            default:         ;
         endcase
      end
   end

   // ************************************************************
   // register read port
   // ************************************************************
   always @*
   begin
      rdata_nxt = 32'h00000000;
      case (addr_i)
         `A_SIG_PERIOD:   rdata_nxt = {16'h0, signal_meas_period_r};
         `A_SIG_RANGE:    rdata_nxt = range_dec(signal_adc_range_r);
         `A_OFS_PERIOD:   rdata_nxt = {16'h0, offset_meas_period_r};
         `A_OFS_RANGE:    rdata_nxt = range_dec(offset_adc_range_r);
         `A_FREQ_PERIOD:  rdata_nxt = {16'h0, freq_meas_period_r};
         `A_GATE_TIME:    rdata_nxt = {16'h0, cw_count_gate_time_r};
         `A_CTRL:         rdata_nxt = {28'h0, ctrl_r};
         `A_AVG_COUNT:    rdata_nxt = {20'h0, avg_cnt_r};
         `A_SAMPLE_RATE:  rdata_nxt = {14'h0, sample_rate_r};
         `A_TEMP_PERIOD:  rdata_nxt = {16'h0, temp_meas_period_r};
         `A_TEMP_AVG:     rdata_nxt = {24'h0, temp_avg_count_r};
         `A_MASK:         rdata_nxt = {24'h0, send_enable_mask_r};
         `A_RES_INTERVAL: rdata_nxt = {16'h0, results_send_interval_r};
         `A_MOT_INTERVAL: rdata_nxt = {16'h0, motor_send_interval_r};
         `A_STATUS:       rdata_nxt = {26'h0, offset_phase_r, do_temp_o, do_freq_o, do_offset_o,
                                       sig_due_w, run_w};
         `A_FLAGS:        rdata_nxt = {24'h0, send_request_flags_r};
         default:         rdata_nxt = 32'h00000000;
      endcase
   end

   always @(posedge clock_i)
   begin
      if (rst_i)
         rdata_o <= 32'h00000000;
      else if (rd_i)
         rdata_o <= rdata_nxt;
      else
         rdata_o <= 32'h00000000;
   end

   // ************************************************************
   // millisecond and second ticks
   // ************************************************************
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ms_div_r  <= 17'h00000;
         s_div_r   <= 10'h000;
         ms_tick_r <= 1'b0;
         s_tick_r  <= 1'b0;
      end
      else
      begin
         ms_tick_r <= 1'b0;
         s_tick_r  <= 1'b0;
         if (ms_div_r == MS_CYCLES[16:0] - 17'h00001)
         begin
            ms_div_r  <= 17'h00000;
            ms_tick_r <= 1'b1;
            if (s_div_r == `S_DIV_LAST)
            begin
               s_div_r  <= 10'h000;
               s_tick_r <= 1'b1;
            end
            else
               s_div_r <= s_div_r + 10'h001;
         end
         else
            ms_div_r <= ms_div_r + 17'h00001;
      end
   end

   // ************************************************************
   // period timers
   // ************************************************************
   period_gate u_sig (.clock_i(clock_i), .rst_i(rst_i), .tick_i(ms_tick_r), .restart_i(start_w),
                      .period_i(signal_meas_period_r), .due_o(sig_due_w));
   period_gate u_ofs (.clock_i(clock_i), .rst_i(rst_i), .tick_i(s_tick_r), .restart_i(start_w && ofs_due_w),
                      .period_i(offset_meas_period_r), .due_o(ofs_due_w));
   period_gate u_frq (.clock_i(clock_i), .rst_i(rst_i), .tick_i(ms_tick_r), .restart_i(start_w && frq_due_w),
                      .period_i(freq_meas_period_r), .due_o(frq_due_w));
   period_gate u_tmp (.clock_i(clock_i), .rst_i(rst_i), .tick_i(s_tick_r), .restart_i(start_w && tmp_due_w),
                      .period_i(temp_meas_period_r), .due_o(tmp_due_w));
   period_gate u_res (.clock_i(clock_i), .rst_i(rst_i), .tick_i(ms_tick_r),
                      .restart_i(loop_pass_i && granted_w[`BIT_RES_TIME]),
                      .period_i(results_send_interval_r), .due_o(res_due_w));
   period_gate u_mot (.clock_i(clock_i), .rst_i(rst_i), .tick_i(ms_tick_r),
                      .restart_i(loop_pass_i && granted_w[`BIT_MOT_TIME]),
                      .period_i(motor_send_interval_r), .due_o(mot_due_w));

   // ************************************************************
   // cycle scheduling
   // ************************************************************
   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         cycle_start_o      <= 1'b0;
         do_offset_o        <= 1'b0;
         do_freq_o          <= 1'b0;
         do_temp_o          <= 1'b0;
         detector_isolate_o <= 1'b0;
         offset_phase_r     <= 1'b0;
      end
      else
      begin
         cycle_start_o <= start_w;
         // after an offset cycle the next cycle waits until its result is back
         if (meas_ok_i)
            offset_phase_r <= 1'b0;
         // a stale result in the start cycle must not cancel the new offset phase
         if (start_w)
         begin
            do_offset_o    <= ofs_due_w;
            do_freq_o      <= frq_due_w;
            do_temp_o      <= tmp_due_w;
            offset_phase_r <= ofs_due_w;
         end
         detector_isolate_o <= (start_w && ofs_due_w) || (offset_phase_r && !meas_ok_i);
      end
   end

   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         signal_range_o    <= `RST_SIG_RANGE;
         offset_range_o    <= `RST_OFS_RANGE;
         gate_time_o       <= `RST_GATE_TIME;
         substitute_freq_o <= 1'b0;
         avg_count_o       <= `RST_AVG_COUNT;
         sample_rate_o     <= `RST_SAMPLE_RATE;
         temp_avg_o        <= `RST_TEMP_AVG;
      end
      else
      begin
         signal_range_o    <= signal_adc_range_r;
         offset_range_o    <= (offset_meas_period_r == 16'h0000 && follow_w)
                              ? signal_adc_range_r : offset_adc_range_r;
         gate_time_o       <= cw_w ? cw_count_gate_time_r : 16'h0000;
         substitute_freq_o <= !cnt_on_w;
         avg_count_o       <= cw_w ? avg_cnt_r : 12'h001;
         sample_rate_o     <= cw_w ? sample_rate_r : 18'h00000;
         temp_avg_o        <= temp_avg_count_r;
      end
   end

   // ************************************************************
   // request flags and send gate
   // ************************************************************
   always @*
   begin
      flags_nxt = send_request_flags_r;
      if (loop_pass_i)
         flags_nxt = 8'h00;
      // a new request in the evaluation cycle survives to the next pass
      if (meas_ok_i)
         flags_nxt[`BIT_READY] = 1'b1;
      if (res_due_w && !send_request_flags_r[`BIT_RES_TIME])
         flags_nxt[`BIT_RES_TIME] = 1'b1;
      if (mot_due_w && !send_request_flags_r[`BIT_MOT_TIME])
         flags_nxt[`BIT_MOT_TIME] = 1'b1;
      if (swap_alarm_i)
         flags_nxt[`BIT_ALARM] = 1'b1;
   end

   always @(posedge clock_i)
   begin
      if (rst_i)
      begin
         send_request_flags_r <= 8'h00;
         send_o               <= 1'b0;
         send_full_o          <= 1'b0;
         send_last_o          <= 1'b0;
         send_motor_o         <= 1'b0;
         send_alarm_o         <= 1'b0;
      end
      else
      begin
         send_request_flags_r <= flags_nxt;
         send_o       <= loop_pass_i && (granted_w != 8'h00);
         send_full_o  <= loop_pass_i && granted_w[`BIT_READY];
         send_last_o  <= loop_pass_i && granted_w[`BIT_RES_TIME];
         send_motor_o <= loop_pass_i && granted_w[`BIT_MOT_TIME];
         send_alarm_o <= loop_pass_i && granted_w[`BIT_ALARM];
      end
   end
endmodule

// >>> testbench/meas_engine_model.sv
// stand-in for the measurement engine: one result pulse per cycle start, unless a new start cuts a slow answer short
`timescale 1ns/1ns
module meas_engine_model
(
   input  wire clock_i,
   input  wire rst_i,
   input  wire start_i,
   output reg  done_o
);
   reg [3:0] wait_r;
   reg       busy_r;
   reg       slow_r;
   // alternates a prompt and a slow answer so the offset phase varies in length
   always @(posedge clock_i)
   begin
      done_o <= 1'b0;
      if (rst_i)
      begin
         busy_r <= 1'b0;
         slow_r <= 1'b0;
         wait_r <= 4'h0;
      end
      else if (start_i)
      begin
         busy_r <= 1'b1;
         slow_r <= ~slow_r;
         wait_r <= slow_r ? 4'h6 : 4'h0;
      end
      else if (busy_r)
      begin
         if (wait_r == 4'h0)
         begin
            busy_r <= 1'b0;
            done_o <= 1'b1;
         end
         else
            wait_r <= wait_r - 4'h1;
      end
   end
endmodule

// >>> testbench/sched_gate_sva.sv
// assertion checker for the measurement scheduler and send gate
`timescale 1ns/1ns
module sched_gate_sva
(
   input wire        clock_i,
   input wire        rst_i,
   input wire        meas_ok_i,
   input wire        loop_pass_i,
   input wire        cycle_start_o,
   input wire        do_offset_o,
   input wire        detector_isolate_o,
   input wire [2:0]  signal_range_o,
   input wire [11:0] avg_count_o,
   input wire [17:0] sample_rate_o,
   input wire [7:0]  temp_avg_o,
   input wire        send_o,
   input wire        send_full_o,
   input wire        send_last_o,
   input wire        send_motor_o,
   input wire        send_alarm_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   property p_send_cause; send_o |-> $past(loop_pass_i); endproperty
   a_send_cause: assert property (p_send_cause) else $error("send without loop pass");
   property p_send_any;
      send_o == (send_full_o | send_last_o | send_motor_o | send_alarm_o);
   endproperty
   a_send_any: assert property (p_send_any) else $error("send differs from granted bits");
   property p_start_gap; cycle_start_o |=> !cycle_start_o; endproperty
   a_start_gap: assert property (p_start_gap) else $error("cycle starts back to back");
   property p_iso_rise; $rose(detector_isolate_o) |-> cycle_start_o && do_offset_o; endproperty
   a_iso_rise: assert property (p_iso_rise) else $error("isolation outside offset cycle");
   property p_iso_end; detector_isolate_o && meas_ok_i |=> !detector_isolate_o; endproperty
   a_iso_end: assert property (p_iso_end) else $error("isolation held after result");
   property p_range; signal_range_o inside {3'h1, 3'h2, 3'h3, 3'h7}; endproperty
   a_range: assert property (p_range) else $error("illegal signal range code");
   property p_rate_max; sample_rate_o <= 18'h30d40; endproperty
   a_rate_max: assert property (p_rate_max) else $error("sample rate above maximum");
   property p_avg; avg_count_o != 12'h000; endproperty
   a_avg: assert property (p_avg) else $error("zero averaging count");
   property p_temp_avg; temp_avg_o != 8'h00; endproperty
   a_temp_avg: assert property (p_temp_avg) else $error("zero temperature averaging");
   c_full: cover property (send_full_o);
   c_alarm: cover property (send_alarm_o);
   c_iso: cover property ($rose(detector_isolate_o));
endmodule

bind measure_schedule_send_gate sched_gate_sva u_sva (.clock_i(clock_i), .rst_i(rst_i),
   .meas_ok_i(meas_ok_i), .loop_pass_i(loop_pass_i), .cycle_start_o(cycle_start_o),
   .do_offset_o(do_offset_o), .detector_isolate_o(detector_isolate_o),
   .signal_range_o(signal_range_o), .avg_count_o(avg_count_o), .sample_rate_o(sample_rate_o),
   .temp_avg_o(temp_avg_o), .send_o(send_o), .send_full_o(send_full_o),
   .send_last_o(send_last_o), .send_motor_o(send_motor_o), .send_alarm_o(send_alarm_o));

// >>> testbench/measure_schedule_send_gate_tb_top.sv
// self-checking bench for the measurement scheduler and send gate
`timescale 1ns/1ns
`include "sched_map.vh"
module measure_schedule_send_gate_tb_top;
   reg         clock_i = 1'b0;
   reg         rst_i = 1'b1;
   reg  [3:0]  addr_i = 4'h0;
   reg  [31:0] wdata_i = 32'h0;
   reg         wr_i = 1'b0;
   reg         rd_i = 1'b0;
   reg         loop_pass_i = 1'b0;
   reg         swap_alarm_i = 1'b0;
   wire        meas_ok_i;
   wire [31:0] rdata_o;
   wire        cyc, d_ofs, d_frq, d_tmp, iso, sub, snd, s_full, s_last, s_mot, s_alm;
   wire [2:0]  sig_rng, ofs_rng;
   wire [15:0] gate;
   wire [11:0] avg;
   wire [17:0] rate;
   wire [7:0]  tavg;
   integer     errors = 0;
   integer     n_compared = 0;
   integer     cycles = 0;
   integer     i, gap;
   reg  [31:0] v;
   reg  [4:0]  s;

   always #5 clock_i = ~clock_i;

   measure_schedule_send_gate #(.MS_CYCLES(10)) dut (.clock_i(clock_i), .rst_i(rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .meas_ok_i(meas_ok_i), .swap_alarm_i(swap_alarm_i), .loop_pass_i(loop_pass_i),
      .cycle_start_o(cyc), .do_offset_o(d_ofs), .do_freq_o(d_frq), .do_temp_o(d_tmp),
      .detector_isolate_o(iso), .signal_range_o(sig_rng), .offset_range_o(ofs_rng),
      .gate_time_o(gate), .substitute_freq_o(sub), .avg_count_o(avg), .sample_rate_o(rate),
      .temp_avg_o(tavg), .send_o(snd), .send_full_o(s_full), .send_last_o(s_last),
      .send_motor_o(s_mot), .send_alarm_o(s_alm));

   meas_engine_model engine (.clock_i(clock_i), .rst_i(rst_i), .start_i(cyc), .done_o(meas_ok_i));

   // ***********************************************
   // tasks
   // ***********************************************
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         n_compared = n_compared + 1;
         if (seen !== exp)
         begin
            errors = errors + 1;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // strobe tasks leave one idle edge so no strobe is assigned twice in a step
   task wr(input [3:0] a, input [31:0] d);
      begin
         addr_i <= a;
         wdata_i <= d;
         wr_i <= 1'b1;
         @(posedge clock_i);
         wr_i <= 1'b0;
         @(posedge clock_i);
      end
   endtask
   task rd(input [3:0] a, output [31:0] d);
      begin
         addr_i <= a;
         rd_i <= 1'b1;
         @(posedge clock_i);
         rd_i <= 1'b0;
         #1 d = rdata_o;
         @(posedge clock_i);
      end
   endtask
   task pass(output [4:0] r);
      begin
         loop_pass_i <= 1'b1;
         @(posedge clock_i);
         loop_pass_i <= 1'b0;
         #1 r = {s_alm, s_mot, s_last, s_full, snd};
         @(posedge clock_i);
      end
   endtask
   task alarm;
      begin
         swap_alarm_i <= 1'b1;
         @(posedge clock_i);
         swap_alarm_i <= 1'b0;
         @(posedge clock_i);
      end
   endtask
   task settle;
      begin
         repeat (2) @(posedge clock_i);
         #1;
      end
   endtask
   task wait_start;
      begin
         @(posedge clock_i);
         #1;
         while (cyc !== 1'b1)
         begin
            @(posedge clock_i);
            #1;
         end
      end
   endtask
   function [31:0] rst_val(input [3:0] a);
      case (a)
         `A_SIG_RANGE: rst_val = 32'hffffffff;
         `A_OFS_PERIOD: rst_val = {16'h0, `RST_OFS_PERIOD};
         `A_OFS_RANGE: rst_val = {29'h0, `RST_OFS_RANGE};
         `A_GATE_TIME: rst_val = {16'h0, `RST_GATE_TIME};
         `A_CTRL: rst_val = {28'h0, `RST_CTRL};
         `A_AVG_COUNT: rst_val = {20'h0, `RST_AVG_COUNT};
         `A_SAMPLE_RATE: rst_val = {14'h0, `RST_SAMPLE_RATE};
         `A_TEMP_PERIOD: rst_val = {16'h0, `RST_TEMP_PERIOD};
         `A_TEMP_AVG: rst_val = {24'h0, `RST_TEMP_AVG};
         `A_MASK: rst_val = {24'h0, `RST_MASK};
         `A_MOT_INTERVAL: rst_val = {16'h0, `RST_MOT_INT};
         default: rst_val = 32'h0;
      endcase
   endfunction
   task give_verdict;
      begin
         $display("compared %0d errors %0d", n_compared, errors);
         if (errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   // a stuck handshake or scheduler ends the run here
   always @(posedge clock_i)
   begin
      cycles = cycles + 1;
      if (cycles == 60000)
      begin
         errors = errors + 1;
         give_verdict;
      end
   end

   // ***********************************************
   // sequence
   // ***********************************************
   initial
   begin
      repeat (16) @(posedge clock_i);
      rst_i <= 1'b0;
      for (i = 0; i < 14; i = i + 1)
      begin
         rd(i[3:0], v);
         chk(v, rst_val(i[3:0]));
      end
      chk(32'(ofs_rng), 32'h2);
      wr(`A_CTRL, 32'h3);
      repeat (20) @(posedge clock_i);
      wr(`A_MASK, 32'h6);
      pass(s);
      chk(32'(s), 32'hd);
      wr(`A_RES_INTERVAL, 32'h3e8);
      pass(s);
      chk(32'(s[3]), 32'h0);
      wr(`A_MASK, 32'h0);
      alarm;
      pass(s);
      chk(32'(s), 32'h0);
      wr(`A_MASK, 32'h8);
      pass(s);
      chk(32'(s), 32'h0);
      alarm;
      pass(s);
      chk(32'(s), 32'h11);
      wr(`A_OFS_PERIOD, 32'h0);
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(`A_SIG_RANGE, (i == 3) ? 32'hffffffff : i + 1);
         settle;
         chk(32'(sig_rng), (i == 3) ? 32'h7 : i + 1);
         chk(32'(ofs_rng), (i == 3) ? 32'h7 : i + 1);
      end
      wr(`A_SIG_RANGE, 32'h4);
      settle;
      chk(32'(sig_rng), 32'h7);
      wr(`A_CTRL, 32'h5);
      wr(`A_AVG_COUNT, 32'h0);
      wr(`A_SAMPLE_RATE, 32'h30d41);
      wr(`A_TEMP_AVG, 32'h5);
      settle;
      chk({sub, gate, avg}, {1'b1, `RST_GATE_TIME, `RST_AVG_COUNT});
      chk(32'(rate), 32'(`MAX_SAMPLE_RATE));
      chk(32'(tavg), 32'h5);
      wr(`A_AVG_COUNT, 32'hfff);
      settle;
      chk(32'(avg), 32'hfff);
      // motor interval is never set low here, keeping the link unloaded
      wr(`A_TEMP_PERIOD, 32'h0);
      wr(`A_MASK, 32'h1);
      wr(`A_CTRL, 32'hb);
      wait_start;
      chk({d_ofs, d_frq, d_tmp}, 3'h7);
      while (meas_ok_i !== 1'b1)
      begin
         @(posedge clock_i);
         #1;
      end
      @(posedge clock_i);
      pass(s);
      chk(32'(s), 32'h3);
      wr(`A_SIG_PERIOD, 32'h3);
      wr(`A_OFS_PERIOD, 32'h1);
      wait_start;
      gap = 0;
      @(posedge clock_i);
      #1;
      while (cyc !== 1'b1)
      begin
         gap = gap + 1;
         @(posedge clock_i);
         #1;
      end
      chk(32'(gap >= 29), 32'h1);
      chk(32'(d_ofs), 32'h0);
      give_verdict;
   end
endmodule
